// ==== tap_defs.svh ====
/*
 Register indices, field positions, reset values and widths of the tone and
 second PWM block. Assumes inclusion by bare name; definitions only.
*/
// Contract
// R1: Prescaler count read-back register returns live prescaler counter; it is read-only.
// R2: Tone codes 0-7 take prescaler output divided by 2..256; enable clear stops tone.
// R3: Tone codes 8-15 drive tone from timer count bits 0..7 in ascending order.
// R4: PWM active-low bit set drives active phase low, clear drives it high.
// R5: PWM output enable puts waveform on both pins, clear returns them to GPIO.
// R6: PWM frame period equals 10-bit reload from high-bits [5:4] and low byte.
// R7: PWM duty is 10 bits: high-bits [3:2] above write-only duty byte.
// R8: Timer counts down to zero, reloads reload or 0x3FF, or stops in one-shot.
// R9: Prescaler divides by 2..256 by three-bit select, bypassed by disable bit.
// R10: PWM active while timer count is at or below duty value, inactive otherwise.
`ifndef TAP_DEFS_SVH
`define TAP_DEFS_SVH

`define TAP_AXI_ADDR_W 8
`define TAP_IDX_W 6

// Register indices; byte address is four times the index
`define TAP_IDX_TIMER_COUNT 6'h00
`define TAP_IDX_TIMER_CTRL 6'h01
`define TAP_IDX_PRESCALER_CTRL 6'h02
`define TAP_IDX_PRESCALER_COUNT 6'h04
`define TAP_IDX_TONE_CTRL 6'h05
`define TAP_IDX_PWM_B_CTRL 6'h0A
`define TAP_IDX_PWM_B_DUTY_LOW 6'h0C
`define TAP_IDX_TIMER_HIGH_BITS 6'h10

// Timer control fields
`define TAP_TCTRL_ENABLE 0
`define TAP_TCTRL_RELOAD 1
`define TAP_TCTRL_ONE_SHOT 2
// Prescaler control fields
`define TAP_PCTRL_SEL_LSB 0
`define TAP_PCTRL_DISABLE 3
// Tone control fields
`define TAP_TONE_SEL_LSB 0
`define TAP_TONE_ENABLE 7
// PWM control fields
`define TAP_PWM_ACTIVE_LOW 6
`define TAP_PWM_OUTPUT_ENABLE 7

// Reset values, and the timer reload used on underflow when reload is clear
`define TAP_RST_PRESCALER_CTRL 4'hF
`define TAP_RST_PRESCALER_COUNT 8'hFF
`define TAP_RST_TONE_SEL 4'hF
`define TAP_TIMER_FULL 10'h3FF

`endif

// ==== tap_pkg.sv ====
/*
 Types shared by the tone and second PWM block.
 Assumes nothing of its surroundings.
*/
package tap_pkg;
   typedef enum logic [1:0] {
      TAP_RESP_OKAY = 2'b00,
      TAP_RESP_SLVERR = 2'b10
   } tap_resp_t;
   typedef logic [9:0] tap_count_t;
endpackage

// ==== tap_tone_pwm.sv ====
/*
 Timer with prescaler, tone output and second PWM channel behind AXI4-Lite.
 Assumes one clock, an active-low asynchronous reset and one outstanding
 read and one outstanding write at a time.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tap_defs.svh"

module tap_tone_pwm (
   input wire logic CLK_SYS, // System clock, 100 MHz
   input wire logic NRST, // Asynchronous reset, active low
   input wire logic [7:0] S_AXI_AWADDR, // Write address
   input wire logic S_AXI_AWVALID, // Write address valid
   output logic S_AXI_AWREADY, // Write address ready
   input wire logic [31:0] S_AXI_WDATA, // Write data
   input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes
   input wire logic S_AXI_WVALID, // Write data valid
   output logic S_AXI_WREADY, // Write data ready
   output tap_pkg::tap_resp_t S_AXI_BRESP, // Write response code
   output logic S_AXI_BVALID, // Write response valid
   input wire logic S_AXI_BREADY, // Write response ready
   input wire logic [7:0] S_AXI_ARADDR, // Read address
   input wire logic S_AXI_ARVALID, // Read address valid
   output logic S_AXI_ARREADY, // Read address ready
   output logic [31:0] S_AXI_RDATA, // Read data
   output tap_pkg::tap_resp_t S_AXI_RRESP, // Read response code
   output logic S_AXI_RVALID, // Read data valid
   input wire logic S_AXI_RREADY, // Read data ready
   output logic TONE_OUT, // Tone waveform
   output logic PWM_B_PIN_FIRST_O, // First PWM pin level
   output logic PWM_B_PIN_FIRST_OE, // First PWM pin driven
   output logic PWM_B_PIN_SECOND_O, // Second PWM pin level
   output logic PWM_B_PIN_SECOND_OE // Second PWM pin driven
);
   import tap_pkg::*;

   // Bus state
   logic aw_held;
   logic w_held;
   logic [`TAP_IDX_W-1:0] aw_idx;
   logic [7:0] w_byte;
   logic w_lane;

   // Software-visible state
   logic [7:0] timer_reload_low;
   logic [2:0] timer_ctrl;
   logic [3:0] prescaler_ctrl;
   logic [7:0] prescaler_count;
   logic [3:0] tone_frequency_select;
   logic tone_enable;
   logic pwm_b_active_low;
   logic pwm_b_output_enable;
   logic [7:0] pwm_b_duty_low;
   logic [5:0] timer_high_bits_reg;

   // Running state; the tone divider runs while the tone is off, so a
   // restart begins part way into a period
   tap_count_t timer_a_count;
   logic timer_stopped;
   logic [7:0] tone_divider;

   // Mask of prescaler bits that must be zero for one output pulse
   function automatic logic [7:0] rate_mask(input logic [2:0] sel);
      logic [8:0] full;
      full = 9'h001 << (4'(sel) + 4'h1);
      rate_mask = 8'(full - 9'h001);
   endfunction

   // Index decode shared by both bus directions
   function automatic logic idx_mapped(input logic [`TAP_IDX_W-1:0] idx);
      idx_mapped = (idx == `TAP_IDX_TIMER_COUNT) || (idx == `TAP_IDX_TIMER_CTRL) ||
                   (idx == `TAP_IDX_PRESCALER_CTRL) || (idx == `TAP_IDX_PRESCALER_COUNT) ||
                   (idx == `TAP_IDX_TONE_CTRL) || (idx == `TAP_IDX_PWM_B_CTRL) ||
                   (idx == `TAP_IDX_PWM_B_DUTY_LOW) || (idx == `TAP_IDX_TIMER_HIGH_BITS);
   endfunction

   // Write channel handshakes; address and data may arrive in either order
   wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
   wire w_take = S_AXI_WVALID & S_AXI_WREADY;
   wire wr_fire = aw_held & w_held & ~S_AXI_BVALID;
   wire next_aw_held = (aw_held | aw_take) & ~wr_fire;
   wire next_w_held = (w_held | w_take) & ~wr_fire;
   wire next_bvalid = wr_fire | (S_AXI_BVALID & ~S_AXI_BREADY);
   // Only byte lane 0 carries register bits; a write without it changes nothing
   wire wr_en = wr_fire & w_lane;
   wire wr_timer_count = wr_en & (aw_idx == `TAP_IDX_TIMER_COUNT);
   wire wr_timer_ctrl = wr_en & (aw_idx == `TAP_IDX_TIMER_CTRL);
   wire wr_prescaler_ctrl = wr_en & (aw_idx == `TAP_IDX_PRESCALER_CTRL);
   wire wr_tone_ctrl = wr_en & (aw_idx == `TAP_IDX_TONE_CTRL);
   wire wr_pwm_ctrl = wr_en & (aw_idx == `TAP_IDX_PWM_B_CTRL);
   wire wr_pwm_duty = wr_en & (aw_idx == `TAP_IDX_PWM_B_DUTY_LOW);
   wire wr_high_bits = wr_en & (aw_idx == `TAP_IDX_TIMER_HIGH_BITS);

   // Read channel handshakes
   wire ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
   wire next_rvalid = ar_take | (S_AXI_RVALID & ~S_AXI_RREADY);
   wire [`TAP_IDX_W-1:0] ar_idx = S_AXI_ARADDR[7:2];

   // Read-back selection; write-only registers read as zero
   logic [7:0] rd_byte;
   always_comb begin
      case (ar_idx)
         `TAP_IDX_TIMER_COUNT: begin
            rd_byte = timer_a_count[7:0];
         end
         `TAP_IDX_TIMER_CTRL: begin
            rd_byte = {5'h00, timer_ctrl};
         end
         `TAP_IDX_PRESCALER_CTRL: begin
            rd_byte = {4'h0, prescaler_ctrl};
         end
         `TAP_IDX_PRESCALER_COUNT: begin
            rd_byte = prescaler_count; // R1
         end
         `TAP_IDX_PWM_B_CTRL: begin
            rd_byte = {pwm_b_output_enable, pwm_b_active_low, 6'h00};
         end
         `TAP_IDX_TIMER_HIGH_BITS: begin
            rd_byte = {2'b00, timer_high_bits_reg};
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end
   // Only the timer count carries bits above the byte
   wire [1:0] rd_upper = (ar_idx == `TAP_IDX_TIMER_COUNT) ? timer_a_count[9:8] : 2'b00;
   wire [31:0] rd_word = {22'h00_0000, rd_upper, rd_byte};

   // Prescaler: free down counter, pulse when the selected low bits are zero
   // Changing the rate mid-count may give one short first period
   wire prescaler_a_disable = prescaler_ctrl[`TAP_PCTRL_DISABLE];
   wire [2:0] prescaler_a_rate_select = prescaler_ctrl[`TAP_PCTRL_SEL_LSB +: 3];
   wire ps_low_zero = (prescaler_count & rate_mask(prescaler_a_rate_select)) == 8'h00;
   wire ps_tick = prescaler_a_disable | ps_low_zero; // R9

   // Timer decode; a count write wins over stepping, so a load is never
   // lost to an underflow in the same cycle
   wire timer_run = timer_ctrl[`TAP_TCTRL_ENABLE] & ~timer_stopped;
   wire timer_step = timer_run & ps_tick;
   wire underflow = timer_step & (timer_a_count == 10'h000);
   wire one_shot = timer_ctrl[`TAP_TCTRL_ONE_SHOT];
   tap_count_t reload_value;
   assign reload_value = {timer_high_bits_reg[5:4], timer_reload_low}; // R6
   tap_count_t next_count;
   assign next_count = wr_timer_count ? {timer_high_bits_reg[5:4], w_byte} :
                       ~underflow ? (timer_step ? timer_a_count - 10'h001 : timer_a_count) :
                       one_shot ? timer_a_count :
                       timer_ctrl[`TAP_TCTRL_RELOAD] ? reload_value : `TAP_TIMER_FULL; // R8

   // Tone source selection; codes 8-15 follow the count even while it is stopped
   wire tone_from_count = tone_frequency_select[3];
   wire [2:0] tone_tap = tone_frequency_select[2:0];
   wire tone_from_div = tone_divider[tone_tap]; // R2
   wire tone_from_timer = timer_a_count[tone_tap]; // R3
   wire next_tone = tone_enable & (tone_from_count ? tone_from_timer : tone_from_div); // R2 R3

   // PWM level: active phase while count at or below duty, within reload frame
   tap_count_t duty_value;
   assign duty_value = {timer_high_bits_reg[3:2], pwm_b_duty_low}; // R7
   wire pwm_active = (timer_a_count <= duty_value); // R10
   wire next_pwm_level = pwm_active ^ pwm_b_active_low; // R4

   // Write path handshake state; ready stays low until the response is
   // handed over, so a second write never queues behind an unread answer
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         S_AXI_AWREADY <= ~next_aw_held & ~next_bvalid;
         S_AXI_WREADY <= ~next_w_held & ~next_bvalid;
         S_AXI_BVALID <= next_bvalid;
      end
   end

   // Write payload capture and response code; an unmapped index answers
   // with an error and changes nothing
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         aw_idx <= 6'h00;
         w_byte <= 8'h00;
         w_lane <= 1'b0;
         S_AXI_BRESP <= TAP_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_idx <= S_AXI_AWADDR[7:2];
         end
         if (w_take) begin
            w_byte <= S_AXI_WDATA[7:0];
            w_lane <= S_AXI_WSTRB[0];
         end
         if (wr_fire) begin
            S_AXI_BRESP <= idx_mapped(aw_idx) ? TAP_RESP_OKAY : TAP_RESP_SLVERR;
         end
      end
   end

   // Read path; data sampled at the address edge, so a count read shows
   // the value at the take, not at the hand-over
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= TAP_RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= ~next_rvalid;
         S_AXI_RVALID <= next_rvalid;
         if (ar_take) begin
            S_AXI_RDATA <= idx_mapped(ar_idx) ? rd_word : 32'h0000_0000;
            S_AXI_RRESP <= idx_mapped(ar_idx) ? TAP_RESP_OKAY : TAP_RESP_SLVERR;
         end
      end
   end

   // Configuration registers
   // Write-only fields have no read path; software keeps its own copy
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         timer_reload_low <= 8'h00;
         timer_ctrl <= 3'h0;
         prescaler_ctrl <= `TAP_RST_PRESCALER_CTRL;
         tone_frequency_select <= `TAP_RST_TONE_SEL;
         tone_enable <= 1'b0;
         pwm_b_active_low <= 1'b0;
         pwm_b_output_enable <= 1'b0;
         pwm_b_duty_low <= 8'h00;
         timer_high_bits_reg <= 6'h00;
      end else begin
         if (wr_timer_count) begin
            timer_reload_low <= w_byte;
         end
         if (wr_timer_ctrl) begin
            timer_ctrl <= w_byte[2:0];
         end
         if (wr_prescaler_ctrl) begin
            prescaler_ctrl <= w_byte[3:0];
         end
         if (wr_tone_ctrl) begin
            tone_frequency_select <= w_byte[`TAP_TONE_SEL_LSB +: 4];
            tone_enable <= w_byte[`TAP_TONE_ENABLE];
         end
         if (wr_pwm_ctrl) begin
            pwm_b_active_low <= w_byte[`TAP_PWM_ACTIVE_LOW];
            pwm_b_output_enable <= w_byte[`TAP_PWM_OUTPUT_ENABLE];
         end
         if (wr_pwm_duty) begin
            pwm_b_duty_low <= w_byte;
         end
         if (wr_high_bits) begin
            timer_high_bits_reg <= w_byte[5:0];
         end
      end
   end

   // Prescaler, timer and tone divider
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         prescaler_count <= `TAP_RST_PRESCALER_COUNT;
         timer_a_count <= 10'h000;
         timer_stopped <= 1'b0;
         tone_divider <= 8'h00;
      end else begin
         prescaler_count <= prescaler_count - 8'h01; // R9
         timer_a_count <= next_count; // R8
         // A new count or control write re-arms a stopped one-shot
         if (wr_timer_count | wr_timer_ctrl) begin
            timer_stopped <= 1'b0;
         end else if (underflow & one_shot) begin
            timer_stopped <= 1'b1; // R8
         end
         if (ps_tick) begin
            tone_divider <= tone_divider + 8'h01; // R2
         end
      end
   end

   // Output flops; both pins carry the same waveform
   // Enable and level register on one edge, so a pin never shows a stale level
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         TONE_OUT <= 1'b0;
         PWM_B_PIN_FIRST_O <= 1'b0;
         PWM_B_PIN_SECOND_O <= 1'b0;
         PWM_B_PIN_FIRST_OE <= 1'b0;
         PWM_B_PIN_SECOND_OE <= 1'b0;
      end else begin
         TONE_OUT <= next_tone; // R2
         PWM_B_PIN_FIRST_O <= next_pwm_level; // R4
         PWM_B_PIN_SECOND_O <= next_pwm_level;
         PWM_B_PIN_FIRST_OE <= pwm_b_output_enable; // R5
         PWM_B_PIN_SECOND_OE <= pwm_b_output_enable; // R5
      end
   end

endmodule

`default_nettype wire

// ==== tap_tone_pwm_asserts.sv ====
/*
 Port checker for the tone and second PWM block: bus timing and pin pairing.
 Assumes a bind onto tap_tone_pwm, one clock and the reset NRST.
*/
`timescale 1ns/1ps
`default_nettype none
module tap_tone_pwm_chk import tap_pkg::*; (
   input wire logic CLK_SYS, // Clock
   input wire logic NRST, // Reset, active low
   input wire logic S_AXI_AWVALID, // Write address valid
   input wire logic S_AXI_AWREADY, // Write address ready
   input wire logic S_AXI_WVALID, // Write data valid
   input wire logic S_AXI_WREADY, // Write data ready
   input wire logic [1:0] S_AXI_BRESP, // Write response
   input wire logic S_AXI_BVALID, // Write response valid
   input wire logic S_AXI_BREADY, // Write response ready
   input wire logic S_AXI_ARVALID, // Read address valid
   input wire logic S_AXI_ARREADY, // Read address ready
   input wire logic [31:0] S_AXI_RDATA, // Read data
   input wire logic [1:0] S_AXI_RRESP, // Read response
   input wire logic S_AXI_RVALID, // Read data valid
   input wire logic S_AXI_RREADY, // Read data ready
   input wire logic PWM_B_PIN_FIRST_O, // First pin level
   input wire logic PWM_B_PIN_FIRST_OE, // First pin driven
   input wire logic PWM_B_PIN_SECOND_O, // Second pin level
   input wire logic PWM_B_PIN_SECOND_OE // Second pin driven
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   property p_rd; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY; endproperty
   a_rd: assert property (p_rd) else $error("read answer late");
   property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
   a_rhold: assert property (p_rhold) else $error("read data not held");
   property p_rclr; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY; endproperty
   a_rclr: assert property (p_rclr) else $error("read not closed");
   property p_rwid; S_AXI_RVALID |-> S_AXI_RDATA[31:10] == 22'h00_0000; endproperty
   a_rwid: assert property (p_rwid) else $error("read upper bits set");
   property p_rerr; S_AXI_RVALID && S_AXI_RRESP == TAP_RESP_SLVERR |-> S_AXI_RDATA == 32'h0000_0000; endproperty
   a_rerr: assert property (p_rerr) else $error("error read carries data");
   property p_wr; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID; endproperty
   a_wr: assert property (p_wr) else $error("write answer late");
   property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
   a_bhold: assert property (p_bhold) else $error("write response not held");
   property p_bclr; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY; endproperty
   a_bclr: assert property (p_bclr) else $error("write not closed");
   property p_bwait; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
   a_bwait: assert property (p_bwait) else $error("write taken before response");
   property p_pins; PWM_B_PIN_FIRST_O == PWM_B_PIN_SECOND_O && PWM_B_PIN_FIRST_OE == PWM_B_PIN_SECOND_OE; endproperty
   a_pins: assert property (p_pins) else $error("pwm pins differ");
endmodule
`default_nettype wire

// ==== tap_pin_load.sv ====
/*
 Load on a PWM pin: the wire follows the block while it drives it.
 Assumes one clock; a released wire has no pull resistor.
*/
`timescale 1ns/1ps
`default_nettype none
module tap_pin_load (
   input wire logic clk, // Clock
   input wire logic nrst, // Reset, active low
   input wire logic pin_o, // Level from block
   input wire logic pin_oe, // Block drives pin
   output logic level // Wire level seen
);
   logic last;
   // Released wire shows the inverse of the last driven level, so stale data never looks driven
   assign level = pin_oe ? pin_o : ~last;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) last <= 1'b0;
      else if (pin_oe) last <= pin_o;
   end
endmodule
`default_nettype wire

// ==== test_tap_tone_pwm.sv ====
/*
 Bench for the tone and second PWM block over AXI4-Lite, with a pin load.
 Assumes the design, checker and load model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tap_defs.svh"
module test_tap_tone_pwm;
   import tap_pkg::*;
   logic clk = 0, nrst = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0000_0000, rdata;
   logic awr, wrdy, bv, arr, rv, tone, p1, p1e, p2, p2e, lvl, t_prev;
   tap_resp_t bresp, rresp, resp;
   int err_count = 0, total_checks = 0, togg, hi;
   always #5 clk = ~clk;
   tap_tone_pwm i_tap_tone_pwm (.CLK_SYS(clk), .NRST(nrst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
      .TONE_OUT(tone), .PWM_B_PIN_FIRST_O(p1), .PWM_B_PIN_FIRST_OE(p1e), .PWM_B_PIN_SECOND_O(p2),
      .PWM_B_PIN_SECOND_OE(p2e));
   tap_pin_load i_tap_pin_load (.clk(clk), .nrst(nrst), .pin_o(p1), .pin_oe(p1e), .level(lvl));
   task automatic results();
      $display("Checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Address and data offered together, each dropped once taken; only the watchdog ends a wait
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      @(posedge clk);
      awa <= {idx, 2'b00};
      wd <= {24'h00_0000, d};
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
      end while (bv !== 1'b1);
      br <= 1'b0;
      resp = bresp;
   endtask
   task automatic rd(input logic [5:0] idx, output logic [31:0] d);
      @(posedge clk);
      ara <= {idx, 2'b00};
      arv <= 1'b1;
      rr <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      rr <= 1'b0;
      d = rdata;
      resp = rresp;
   endtask
   // Settle a few cycles, then count tone edges and high pin cycles
   task automatic meas(input int n);
      repeat (4) @(posedge clk);
      togg = 0;
      hi = 0;
      t_prev = tone;
      repeat (n) begin
         @(posedge clk);
         if (tone !== t_prev) togg++;
         if (lvl === 1'b1) hi++;
         t_prev = tone;
      end
   endtask
   initial begin
      logic [31:0] v, w;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      rd(`TAP_IDX_PWM_B_CTRL, v);
      chk("pwm ctrl reset", 32'h0000_0000, v);
      rd(`TAP_IDX_TONE_CTRL, v);
      chk("tone ctrl read", 32'h0000_0000, v);
      rd(`TAP_IDX_PWM_B_DUTY_LOW, v);
      chk("duty read", 32'h0000_0000, v);
      rd(`TAP_IDX_PRESCALER_COUNT, v);
      rd(`TAP_IDX_PRESCALER_COUNT, w);
      chk("readback moves", 32'h0000_0001, v !== w);
      rd(6'h3F, v);
      chk("unmapped read", TAP_RESP_SLVERR, resp);
      wr(6'h3F, 8'hFF);
      chk("unmapped write", TAP_RESP_SLVERR, resp);
      wr(`TAP_IDX_PWM_B_CTRL, 8'hC0);
      rd(`TAP_IDX_PWM_B_CTRL, v);
      chk("pwm ctrl rw", 32'h0000_00C0, v);
      // Free-running timer from 0x3FF, prescaler bypassed: every code, one tick a clock
      wr(`TAP_IDX_TIMER_CTRL, 8'h01);
      for (int c = 0; c < 16; c++) begin
         wr(`TAP_IDX_TONE_CTRL, 8'h80 | 8'(c));
         meas(256);
         chk("tone edges", 256 >> (c % 8), togg);
      end
      // Every rate select, seen on the fastest divider code, code 0
      for (int s = 0; s < 8; s++) begin
         wr(`TAP_IDX_PRESCALER_CTRL, 8'(s));
         wr(`TAP_IDX_TONE_CTRL, 8'h80);
         meas(256);
         chk("prescaler rate", 128 >> s, togg);
      end
      wr(`TAP_IDX_PRESCALER_CTRL, 8'h08);
      wr(`TAP_IDX_TONE_CTRL, 8'h08);
      meas(256);
      chk("tone disabled edges", 0, togg);
      chk("tone disabled level", 0, tone);
      // One-shot from 0x020 stops at zero
      wr(`TAP_IDX_TIMER_CTRL, 8'h05);
      wr(`TAP_IDX_TIMER_COUNT, 8'h20);
      wr(`TAP_IDX_TONE_CTRL, 8'h88);
      repeat (40) @(posedge clk);
      meas(64);
      chk("one-shot stopped", 0, togg);
      rd(`TAP_IDX_TIMER_COUNT, v);
      chk("one-shot count", 32'h0000_0000, v);
      // Reload 0x010 gives 17-state frames, duty 4 gives 5 active states
      wr(`TAP_IDX_TIMER_CTRL, 8'h03);
      wr(`TAP_IDX_TIMER_COUNT, 8'h10);
      wr(`TAP_IDX_PWM_B_DUTY_LOW, 8'h04);
      wr(`TAP_IDX_PWM_B_CTRL, 8'h80);
      meas(68);
      chk("pwm high", 20, hi);
      chk("pwm driven", 1, p1e);
      wr(`TAP_IDX_PWM_B_CTRL, 8'hC0);
      meas(68);
      chk("pwm active low", 48, hi);
      wr(`TAP_IDX_TIMER_HIGH_BITS, 8'h0C);
      meas(68);
      chk("pwm duty high", 0, hi);
      // Reload 0x110 after the next underflow: 273-state frames
      wr(`TAP_IDX_TIMER_HIGH_BITS, 8'h10);
      repeat (300) @(posedge clk);
      meas(546);
      chk("pwm long frame", 536, hi);
      wr(`TAP_IDX_PWM_B_CTRL, 8'h00);
      repeat (2) @(posedge clk);
      chk("pins released", 0, {p1e, p2e});
      results();
   end
   // Run takes about 8k cycles; cut a hang well beyond that
   initial begin
      #500_000;
      err_count++;
      results();
   end
endmodule
bind tap_tone_pwm tap_tone_pwm_chk i_tap_tone_pwm_chk (.*);
`default_nettype wire
